// >>> psram_wr_pkg.sv
package psram_wr_pkg;
  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 16;
  localparam int DEPTH     = 256;
  localparam int LANE_LO   = 0;
  localparam int LANE_HI   = 8;
  localparam int LANE_W    = 8;
  localparam logic [15:0] MEM_RESET = 16'h0000;
  localparam logic [2:0]  SYNC_RESET_N = 3'h7;
endpackage

// >>> psram_async_write_port.sv
module psram_async_write_port
  import psram_wr_pkg::*;
(
  // system
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // memory pins
  input  wire logic              chip_sel_n,
  input  wire logic              write_en_n,
  input  wire logic              upper_byte_sel_n,
  input  wire logic              lower_byte_sel_n,
  input  wire logic              address_valid_n,
  input  wire logic              latch_mode,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  // wait pin, never driven by this port
  output logic                   wait_n_out,
  output logic                   wait_n_oe,
  // read-back of the array and status
  input  wire logic [ADDR_W-1:0] peek_addr,
  output logic [DATA_W-1:0]      peek_data,
  output logic                   write_active
);

  ////////////////////////////////////////////////////////////////////////////
  logic [2:0]        s1_reg;
  logic [2:0]        s2_reg;
  logic              adv1_reg;
  logic              adv2_reg;
  logic              lm1_reg;
  logic              lm2_reg;
  logic [ADDR_W-1:0] a1_reg;
  logic [ADDR_W-1:0] a2_reg;
  logic [DATA_W-1:0] d1_reg;
  logic [DATA_W-1:0] d2_reg;
  logic [ADDR_W-1:0] latch_addr_reg;
  logic [DATA_W-1:0] mem_reg [DEPTH];
  logic              active_reg;
  logic [DATA_W-1:0] peek_reg;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s1_reg   <= SYNC_RESET_N;
      s2_reg   <= SYNC_RESET_N;
      adv1_reg <= 1'b1;
      adv2_reg <= 1'b1;
      lm1_reg  <= 1'b0;
      lm2_reg  <= 1'b0;
    end else begin
      s1_reg   <= {chip_sel_n, write_en_n, 1'b0};
      s2_reg   <= s1_reg;
      adv1_reg <= address_valid_n;
      adv2_reg <= adv1_reg;
      // mode pin comes from outside, same two-stage lag as the strobes
      lm1_reg  <= latch_mode;
      lm2_reg  <= lm1_reg;
    end
  end

  // bus is held stable over the window, so two stages suffice
  always_ff @(posedge sys_clk) begin
    a1_reg <= addr;
    a2_reg <= a1_reg;
    d1_reg <= {upper_byte_sel_n ? 8'h00 : wdata[15:8], wdata[7:0]};
    d2_reg <= d1_reg;
  end

  logic [1:0] be1_reg;
  logic [1:0] be2_reg;
  always_ff @(posedge sys_clk) begin
    be1_reg <= {~upper_byte_sel_n, ~lower_byte_sel_n};
    be2_reg <= be1_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // overlap of strobes
  wire cs_low     = ~s2_reg[2];
  wire we_low     = ~s2_reg[1];
  wire win        = cs_low & we_low;
  wire win_end    = active_reg & ~win;
  wire adv_low    = ~adv2_reg;
  wire latched    = lm2_reg;
  // plain mode never looks at address valid
  wire [ADDR_W-1:0] wr_addr = latched ? latch_addr_reg : a2_reg;

  // data committed at the end of the window, when it is settled
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      active_reg     <= 1'b0;
      latch_addr_reg <= '0;
    end else begin
      active_reg <= win;
      if (adv_low && latched) begin
        latch_addr_reg <= a2_reg;
      end
    end
  end

  logic [DATA_W-1:0] last_d_reg;
  logic [1:0]        last_be_reg;
  always_ff @(posedge sys_clk) begin
    if (win) begin
      last_d_reg  <= d2_reg;
      last_be_reg <= be2_reg;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (win_end && last_be_reg[0]) begin
      mem_reg[wr_addr][LANE_LO +: LANE_W] <= last_d_reg[LANE_LO +: LANE_W];
    end
    if (win_end && last_be_reg[1]) begin
      mem_reg[wr_addr][LANE_HI +: LANE_W] <= last_d_reg[LANE_HI +: LANE_W];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      peek_reg <= MEM_RESET;
    end else begin
      peek_reg <= mem_reg[peek_addr];
    end
  end

  assign peek_data    = peek_reg;
  assign write_active = active_reg;
  assign wait_n_out   = 1'b1;
  assign wait_n_oe    = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // window follows overlap
  AST_WIN_TRACK: assert property (@(posedge sys_clk) disable iff (rst)
    active_reg == $past(win))
    else $error("active does not follow strobe overlap");

  AST_END_ON_RISE: assert property (@(posedge sys_clk) disable iff (rst)
    (active_reg && (s2_reg[2] || s2_reg[1])) |=> !active_reg)
    else $error("write did not end on strobe rise");

  AST_NO_WAIT: assert property (@(posedge sys_clk) disable iff (rst)
    !wait_n_oe)
    else $error("wait pin driven");

  AST_WAIT_HIGH: assert property (@(posedge sys_clk) disable iff (rst)
    wait_n_out)
    else $error("wait level not high");

  AST_LANE_KEEP: assert property (@(posedge sys_clk) disable iff (rst)
    (win_end && !last_be_reg[1] && wr_addr == peek_addr)
      |=> ##1 peek_data[15:8] == $past(mem_reg[peek_addr][15:8], 2))
    else $error("unselected lane changed");

  AST_LO_LANE_KEEP: assert property (@(posedge sys_clk) disable iff (rst)
    (win_end && !last_be_reg[0] && wr_addr == peek_addr)
      |=> ##1 peek_data[7:0] == $past(mem_reg[peek_addr][7:0], 2))
    else $error("unselected lower lane changed");

  AST_LO_LANE_WRITE: assert property (@(posedge sys_clk) disable iff (rst)
    (win_end && last_be_reg[0])
      |=> mem_reg[$past(wr_addr)][LANE_LO +: LANE_W]
          == $past(last_d_reg[LANE_LO +: LANE_W]))
    else $error("lower lane not written");

  AST_HI_LANE_WRITE: assert property (@(posedge sys_clk) disable iff (rst)
    (win_end && last_be_reg[1])
      |=> mem_reg[$past(wr_addr)][LANE_HI +: LANE_W]
          == $past(last_d_reg[LANE_HI +: LANE_W]))
    else $error("upper lane not written");

  AST_NO_ACT_IDLE: assert property (@(posedge sys_clk) disable iff (rst)
    (s2_reg[2] ##1 s2_reg[2]) |-> !active_reg)
    else $error("active without chip select");

  AST_END_PULSE: assert property (@(posedge sys_clk) disable iff (rst)
    win_end |=> !win_end)
    else $error("window end lasted two cycles");

  AST_LATCH_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
    !(adv_low && latched) |=> $stable(latch_addr_reg))
    else $error("latched address moved without strobe");

  C_WORD: cover property (@(posedge sys_clk) win_end && &last_be_reg);
  C_BYTE: cover property (@(posedge sys_clk) win_end && ^last_be_reg);
  C_LATCH: cover property (@(posedge sys_clk) win_end && latched);
  // window with no lane selected: nothing lands
  C_NO_LANE: cover property (@(posedge sys_clk) win_end && !(|last_be_reg));
endmodule

// >>> host_ctrl.sv
module host_ctrl
  import psram_wr_pkg::*;
(
  // clock
  input  wire logic              sys_clk,
  // memory pins
  output logic                   chip_sel_n,
  output logic                   write_en_n,
  output logic                   upper_byte_sel_n,
  output logic                   lower_byte_sel_n,
  output logic                   address_valid_n,
  output logic [ADDR_W-1:0]      addr,
  output logic [DATA_W-1:0]      wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {chip_sel_n, write_en_n, address_valid_n} = 3'h7;
    {upper_byte_sel_n, lower_byte_sel_n} = 2'h3;
    addr = 8'h00;
    wdata = 16'h0000;
  end
  // m: 0 end by we, 1 end by cs, 2 we kept high
  // selects, adv, address held
  task automatic wr(input logic [7:0] a, input logic [15:0] d,
                    input logic [1:0] sel_n, input int m);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    {upper_byte_sel_n, lower_byte_sel_n} <= sel_n;
    address_valid_n <= 1'b0;
    chip_sel_n <= 1'b0;
    write_en_n <= (m == 2);
    repeat (8) @(posedge sys_clk);
    if (m == 1) chip_sel_n <= 1'b1;
    else write_en_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    // we high gap between back-to-back writes
    {chip_sel_n, write_en_n, address_valid_n} <= 3'h7;
    {upper_byte_sel_n, lower_byte_sel_n} <= 2'h3;
    addr <= ~a;
    wdata <= ~d;
    repeat (3) @(posedge sys_clk);
  endtask
endmodule

// >>> tb.sv
module tb;
  import psram_wr_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, rst, latch_mode, wait_n_out, wait_n_oe, write_active;
  logic chip_sel_n, write_en_n, upper_byte_sel_n, lower_byte_sel_n;
  logic address_valid_n;
  logic [7:0] addr, peek_addr;
  logic [15:0] wdata, peek_data;
  int fail_count = 0, cmp_count = 0, cyc = 0;
  int act_total = 0, act_base = 0;
  host_ctrl host_ctrl_i(
    .sys_clk          (sys_clk),
    .chip_sel_n       (chip_sel_n),
    .write_en_n       (write_en_n),
    .upper_byte_sel_n (upper_byte_sel_n),
    .lower_byte_sel_n (lower_byte_sel_n),
    .address_valid_n  (address_valid_n),
    .addr             (addr),
    .wdata            (wdata)
  );
  psram_async_write_port psram_async_write_port_i(
    .sys_clk          (sys_clk),
    .rst              (rst),
    .chip_sel_n       (chip_sel_n),
    .write_en_n       (write_en_n),
    .upper_byte_sel_n (upper_byte_sel_n),
    .lower_byte_sel_n (lower_byte_sel_n),
    .address_valid_n  (address_valid_n),
    .latch_mode       (latch_mode),
    .addr             (addr),
    .wdata            (wdata),
    .wait_n_out       (wait_n_out),
    .wait_n_oe        (wait_n_oe),
    .peek_addr        (peek_addr),
    .peek_data        (peek_data),
    .write_active     (write_active)
  );
  // window length, sampled away from the launching edge
  always @(negedge sys_clk) begin
    if (write_active === 1'b1) act_total++;
  end
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic stop_test();
    $display("counts: %0d compares, %0d mismatches", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      stop_test();
    end
  end
  task automatic chk(input logic [7:0] a, input logic [15:0] e, input int n);
    @(posedge sys_clk);
    peek_addr <= a;
    repeat (2) @(posedge sys_clk);
    #1;
    cmp_count++;
    if (peek_data !== e || wait_n_oe !== 1'b0 || wait_n_out !== 1'b1) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, peek_data, e);
    end
    cmp_count++;
    if (act_total - act_base != n) begin
      fail_count++;
      $display("MISMATCH t=%0t window %0d exp %0d", $time,
               act_total - act_base, n);
    end
    act_base = act_total;
  endtask
  task automatic t_lanes();
    host_ctrl_i.wr(8'h3c, 16'ha55a, 2'h0, 0);
    chk(8'h3c, 16'ha55a, 8);
    host_ctrl_i.wr(8'h3c, 16'h1234, 2'h2, 1);
    chk(8'h3c, 16'ha534, 8);
    host_ctrl_i.wr(8'h3c, 16'hbeef, 2'h1, 0);
    chk(8'h3c, 16'hbe34, 8);
    $display("t_lanes done");
  endtask
  task automatic t_refuse();
    host_ctrl_i.wr(8'h3c, 16'h0000, 2'h0, 2);
    chk(8'h3c, 16'hbe34, 0);
    host_ctrl_i.wr(8'h3c, 16'h0000, 2'h3, 0);
    chk(8'h3c, 16'hbe34, 8);
    $display("t_refuse done");
  endtask
  task automatic t_latch();
    @(posedge sys_clk);
    latch_mode <= 1'b1;
    host_ctrl_i.wr(8'hc3, 16'h0f0f, 2'h0, 0);
    chk(8'hc3, 16'h0f0f, 8);
    @(posedge sys_clk);
    latch_mode <= 1'b0;
    $display("t_latch done");
  endtask
  initial begin
    rst = 1'b1;
    latch_mode = 1'b0;
    peek_addr = 8'h00;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    t_lanes();
    t_refuse();
    t_latch();
    stop_test();
  end
endmodule
